// ==== verilog/olk_pkg.sv ====
/*
 one-time lockout latch: shared constants for key, vote threshold and widths.
 assumes nothing beyond a SystemVerilog compiler.
*/
package olk_pkg;
  localparam int unsigned KEY_W = 32;
  // key pattern value is arbitrary
  localparam logic [31:0] LOCK_KEY = 32'ha5c3_96e1;
  localparam int unsigned VOTE_MIN = 28;
  localparam int unsigned CNT_W = 6;
  localparam logic [31:0] CELL_RST = 32'h0000_0000;
  localparam int unsigned PROT_W = 2;
  localparam logic [1:0] PROT_NONE = 2'h0;
endpackage

// ==== verilog/olk_vote.sv ====
/*
 majority vote of stored latch bits against the key pattern.
 assumes the cell value is stable while it is compared.
*/
`timescale 1ns/1ps
module olk_vote #(
  parameter int unsigned W = olk_pkg::KEY_W,
  parameter int unsigned MIN = olk_pkg::VOTE_MIN
) (
  input wire logic [W-1:0] cells_i, // stored bits
  input wire logic [W-1:0] key_i, // reference pattern
  output logic match_o // at least MIN bits agree
);
  logic [W-1:0] agree;
  logic [olk_pkg::CNT_W-1:0] cnt;
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      assign agree[g] = ~(cells_i[g] ^ key_i[g]);
    end
  endgenerate
  always_comb
  begin
    cnt = '0;
    for (int i = 0; i < W; i++)
      cnt = cnt + olk_pkg::CNT_W'(agree[i]);
    match_o = (cnt >= olk_pkg::CNT_W'(MIN));
  end
endmodule // olk_vote

// ==== verilog/olk_lock.sv ====
/*
 lockout latch with volatile key copy, nonvolatile commit, reset-time vote,
 debug/test port gating and flash-protection interlocks.
 assumes synchronous inputs, one-cycle request strobes, and that the
 nonvolatile cell array is modelled by a register that keeps its value
 through resetn_i (only a commit changes it).
*/
`timescale 1ns/1ps
// What this block does
// - latch holds thirty-two bits in four bytes
// - lock when twenty-eight or more bits match
// - locked device disables all debug and test ports
// - locked latch contents can never be altered
// - write key, commit cells, then reset
// - lock output sampled only during reset
// - key write only without flash protection
// - full access continues until next reset
// - latch contents readable over debug port
// - protection cleared only by full erase or reset
// - block operations obey block security settings
module olk_lock #(
  parameter int unsigned BLOCKS = 4
) (
  input wire logic ref_clk_i, // system clock
  input wire logic resetn_i, // sync reset, active low
  input wire logic key_wr_i, // write volatile copy strobe
  input wire logic [olk_pkg::KEY_W-1:0] key_i, // key data
  input wire logic commit_i, // commit copy to cells strobe
  input wire logic dbg_req_i, // debug/test entry request
  input wire logic prot_wr_i, // raise protection strobe
  input wire logic [olk_pkg::PROT_W-1:0] prot_i, // requested level
  input wire logic full_erase_i, // full device erase strobe
  input wire logic blk_op_i, // block op request strobe
  input wire logic [$clog2(BLOCKS)-1:0] blk_sel_i, // block index
  input wire logic [BLOCKS-1:0] blk_allow_i, // per-block security permits
  output logic locked_o, // sampled lock, ports disabled
  output logic dbg_en_o, // debug/test ports enabled
  output logic [olk_pkg::KEY_W-1:0] cells_o, // latch readout
  output logic [olk_pkg::PROT_W-1:0] prot_o, // flash protection level
  output logic blk_go_o, // block op granted pulse
  output logic key_ack_o, // key write accepted pulse
  output logic commit_ack_o // commit accepted pulse
);
  typedef enum logic [1:0] {OLK_EMPTY, OLK_LOADED, OLK_COMMITTED} olk_seq_t;

  // nonvolatile, survives reset; starts blank so the vote is defined before any commit
  logic [olk_pkg::KEY_W-1:0] cells = olk_pkg::CELL_RST;
  logic [olk_pkg::KEY_W-1:0] next_cells;
  logic key_take;
  logic [olk_pkg::KEY_W-1:0] vcopy, next_vcopy;
  logic [olk_pkg::PROT_W-1:0] prot, next_prot;
  logic locked, next_locked;
  logic dbg_en, next_dbg_en;
  logic blk_go, next_blk_go;
  logic key_ack, next_key_ack;
  logic commit_ack, next_commit_ack;
  logic in_reset, next_in_reset;
  olk_seq_t seq, next_seq;
  logic vote;
  logic cell_lock;

  olk_vote #(.W(olk_pkg::KEY_W), .MIN(olk_pkg::VOTE_MIN)) u_vote (
    .cells_i(cells),
    .key_i(olk_pkg::LOCK_KEY),
    .match_o(vote)
  );

  // lock state of the cells now, for write gating only
  assign cell_lock = vote;

  // key write accepted this cycle; it wins over a commit in the same cycle
  assign key_take = key_wr_i && prot == olk_pkg::PROT_NONE && !cell_lock;

  // nonvolatile cells: never reset, never written once locked
  always_comb
  begin
    next_cells = cells;
    // no commit while reset is held, and none when a key write takes the cycle
    if (resetn_i && commit_i && !key_take && seq == OLK_LOADED && !cell_lock)
      next_cells = vcopy;
  end

  always_ff @(posedge ref_clk_i)
    cells <= next_cells;

  // volatile copy, commit sequence, protection, handshakes
  always_comb
  begin
    next_vcopy = vcopy;
    next_seq = seq;
    next_prot = prot;
    next_key_ack = 1'b0;
    next_commit_ack = 1'b0;
    next_blk_go = 1'b0;
    next_in_reset = 1'b0;
    if (key_wr_i && prot == olk_pkg::PROT_NONE && !cell_lock)
    begin
      next_vcopy = key_i;
      next_seq = OLK_LOADED;
      next_key_ack = 1'b1;
    end
    else if (commit_i && seq == OLK_LOADED && !cell_lock)
    begin
      next_seq = OLK_COMMITTED;
      next_commit_ack = 1'b1;
    end
    if (full_erase_i && !locked)
      next_prot = olk_pkg::PROT_NONE;
    else if (prot_wr_i && prot_i > prot && !locked)
      next_prot = prot_i;
    if (blk_op_i && !locked && blk_allow_i[blk_sel_i])
      next_blk_go = 1'b1;
  end

  // lock decision: sampled only while reset is held
  always_comb
  begin
    next_locked = locked;
    if (!resetn_i)
      next_locked = vote;
    next_dbg_en = !next_locked && (dbg_req_i || dbg_en) && resetn_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      vcopy <= olk_pkg::CELL_RST;
      seq <= OLK_EMPTY;
      prot <= olk_pkg::PROT_NONE;
      key_ack <= 1'b0;
      commit_ack <= 1'b0;
      blk_go <= 1'b0;
      in_reset <= 1'b1;
    end
    else
    begin
      vcopy <= next_vcopy;
      seq <= next_seq;
      prot <= next_prot;
      key_ack <= next_key_ack;
      commit_ack <= next_commit_ack;
      blk_go <= next_blk_go;
      in_reset <= next_in_reset;
    end
  end

  // lock flop deliberately not reset to a constant: it takes the vote
  always_ff @(posedge ref_clk_i)
  begin
    locked <= next_locked;
    dbg_en <= next_dbg_en;
  end

  assign locked_o = locked;
  assign dbg_en_o = dbg_en;
  assign cells_o = cells;
  assign prot_o = prot;
  assign blk_go_o = blk_go;
  assign key_ack_o = key_ack;
  assign commit_ack_o = commit_ack;

  sequence s_loaded;
    key_ack;
  endsequence
  sequence s_committed;
    ##[1:1000] commit_ack;
  endsequence

  lock_hold_a: assert property (@(posedge ref_clk_i) resetn_i && $past(resetn_i) |->
    locked == $past(locked)) else $error("lock changed outside reset");
  lock_sample_a: assert property (@(posedge ref_clk_i) in_reset |->
    locked == $past(vote)) else $error("lock not sampled from vote");
  port_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    locked |-> !dbg_en) else $error("debug enabled while locked");
  cell_freeze_a: assert property (@(posedge ref_clk_i) cell_lock |=> $stable(cells))
    else $error("locked cells altered");
  key_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    key_ack |-> $past(prot) == olk_pkg::PROT_NONE) else $error("key taken under protection");
  commit_order_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(commit_ack) |-> $past(seq, 2) == OLK_LOADED || $past(seq) == OLK_LOADED)
    else $error("commit without loaded key");
  key_then_commit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_loaded ##0 (commit_i && !cell_lock) [*1] |=> commit_ack) else $error("commit lost");
  access_kept_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_loaded ##0 !locked |-> s_committed or ##[1:1000] !locked) else $error("access lost early");
  prot_lower_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    prot < $past(prot) |-> $past(full_erase_i)) else $error("protection lowered without erase");
  blk_perm_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    blk_go |-> $past(blk_allow_i[blk_sel_i]) && !$past(locked)) else $error("block op not permitted");
  vote_cnt_a: assert property (@(posedge ref_clk_i)
    cells == olk_pkg::LOCK_KEY |-> vote) else $error("full match not voted");

  // multi-step views of the key load and the commit
  sequence s_key_written;
    key_take ##1 key_ack;
  endsequence
  sequence s_commit_step;
    (commit_i && seq == OLK_LOADED && !key_take && !cell_lock) ##1 commit_ack;
  endsequence
  sequence s_armed;
    commit_ack ##0 vote ##0 !locked;
  endsequence

  // key write path
  key_take_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    key_take
    |=> key_ack)
    else $error("allowed key write not taken");
  key_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    key_wr_i && prot != olk_pkg::PROT_NONE
    |=> !key_ack)
    else $error("key taken while protected");
  key_copy_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    key_ack
    |-> vcopy == $past(key_i))
    else $error("volatile copy differs from key");
  key_seq_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_key_written
    |-> seq == OLK_LOADED)
    else $error("key load not recorded");
  vcopy_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $past(resetn_i) && !key_ack
    |-> $stable(vcopy))
    else $error("volatile copy changed without write");

  // commit path
  commit_copy_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    commit_ack
    |-> cells == $past(vcopy))
    else $error("cells differ from committed copy");
  commit_flow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_commit_step
    |-> seq == OLK_COMMITTED)
    else $error("commit step not completed");
  commit_need_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    commit_ack
    |-> $past(seq) == OLK_LOADED)
    else $error("commit without key load");
  commit_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    commit_i && seq != OLK_LOADED
    |=> !commit_ack)
    else $error("commit taken without key");
  key_wins_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    key_take && commit_i
    |=> !commit_ack && $stable(cells))
    else $error("commit taken beside key write");
  cells_commit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cells != $past(cells)
    |-> commit_ack)
    else $error("cells changed without commit");
  lock_key_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cell_lock && key_wr_i
    |=> !key_ack)
    else $error("key taken into locked latch");
  lock_commit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cell_lock && commit_i
    |=> !commit_ack)
    else $error("commit into locked latch");

  // flash protection level
  prot_raise_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    prot_wr_i && !full_erase_i && !locked && prot_i > prot
    |=> prot == $past(prot_i))
    else $error("protection raise lost");
  prot_erase_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    full_erase_i && !locked
    |=> prot == olk_pkg::PROT_NONE)
    else $error("erase left protection set");
  prot_frozen_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    locked
    |=> $stable(prot))
    else $error("protection changed while locked");

  // block operations
  blk_grant_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    blk_op_i && !locked && blk_allow_i[blk_sel_i]
    |=> blk_go)
    else $error("permitted block op refused");
  blk_deny_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    blk_op_i && !blk_allow_i[blk_sel_i]
    |=> !blk_go)
    else $error("forbidden block op granted");
  blk_locked_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    locked
    |=> !blk_go)
    else $error("block op granted while locked");
  blk_cause_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    blk_go
    |-> $past(blk_op_i))
    else $error("block grant without request");

  // debug port gating
  dbg_open_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !locked && dbg_req_i
    |=> dbg_en)
    else $error("debug refused while unlocked");
  dbg_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    dbg_en
    |=> dbg_en)
    else $error("debug dropped before reset");
  dbg_shut_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    locked
    |=> !dbg_en)
    else $error("debug opened while locked");
  dbg_rst_a: assert property (@(posedge ref_clk_i)
    !resetn_i
    |=> !dbg_en)
    else $error("debug open through reset");
  armed_open_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_armed
    |=> !locked)
    else $error("lock before reset");

  // reset behaviour and vote
  rst_clear_a: assert property (@(posedge ref_clk_i)
    !resetn_i
    |=> !key_ack && !commit_ack && !blk_go && seq == OLK_EMPTY)
    else $error("state not cleared by reset");
  rst_flag_a: assert property (@(posedge ref_clk_i)
    !resetn_i
    |=> in_reset)
    else $error("reset flag not set");
  run_flag_a: assert property (@(posedge ref_clk_i)
    resetn_i
    |=> !in_reset)
    else $error("reset flag stuck");
  vote_count_a: assert property (@(posedge ref_clk_i)
    vote == ($countones(~(cells ^ olk_pkg::LOCK_KEY)) >= olk_pkg::VOTE_MIN))
    else $error("vote disagrees with bit count");
endmodule // olk_lock

// ==== test/olk_prog.sv ====
/*
 programmer model on the far side: loads a key, then commits it.
 assumes the bench applies reset afterwards and checks the answers.
*/
`timescale 1ns/1ps
module olk_prog (
  input wire logic ref_clk_i, // system clock
  input wire logic key_ack_i, // key accepted pulse
  input wire logic commit_ack_i, // commit accepted pulse
  output logic key_wr_o = 1'b0, // key write strobe
  output logic [olk_pkg::KEY_W-1:0] key_o = 32'h0000_0000, // key data
  output logic commit_o = 1'b0 // commit strobe
);
  task automatic lock_seq(input logic [31:0] k, output logic ka, output logic ca);
    @(negedge ref_clk_i);
    key_wr_o = 1'b1;
    key_o = k;
    @(negedge ref_clk_i);
    ka = key_ack_i;
    key_wr_o = 1'b0;
    key_o = ~k; // released data must not look valid
    commit_o = 1'b1;
    @(negedge ref_clk_i);
    ca = commit_ack_i;
    commit_o = 1'b0;
  endtask
endmodule // olk_prog

// ==== test/tb_top.sv ====
/*
 self-checking bench for the lockout latch.
 assumes olk_prog as programmer; the bench drives reset and other strobes.
*/
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i = 0, resetn_i = 0, dbg_req_i = 0, ka, ca;
  logic [2:0] st = 3'h0;
  logic [1:0] prot_i = 2'h0, blk_sel_i = 2'h0, prot_o;
  logic [3:0] blk_allow_i = 4'h0;
  logic key_wr_i, commit_i, locked_o, dbg_en_o, blk_go_o, key_ack_o, commit_ack_o;
  logic [31:0] key_i, cells_o, k, rnd = 32'h0001_77f5;
  int error_cnt = 0, cmp_count = 0;
  olk_lock i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .key_wr_i(key_wr_i), .key_i(key_i),
    .commit_i(commit_i), .dbg_req_i(dbg_req_i), .prot_wr_i(st[2]), .prot_i(prot_i), .full_erase_i(st[1]),
    .blk_op_i(st[0]), .blk_sel_i(blk_sel_i), .blk_allow_i(blk_allow_i), .locked_o(locked_o),
    .dbg_en_o(dbg_en_o), .cells_o(cells_o), .prot_o(prot_o), .blk_go_o(blk_go_o),
    .key_ack_o(key_ack_o), .commit_ack_o(commit_ack_o));
  olk_prog i_prog (.ref_clk_i(ref_clk_i), .key_ack_i(key_ack_o), .commit_ack_i(commit_ack_o),
    .key_wr_o(key_wr_i), .key_o(key_i), .commit_o(commit_i));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic vote(input logic [31:0] c);
    return $countones(~(c ^ olk_pkg::LOCK_KEY)) >= olk_pkg::VOTE_MIN;
  endfunction
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic pulse(input logic [2:0] m);
    @(negedge ref_clk_i);
    st = m;
    @(negedge ref_clk_i);
    st = 3'h0;
  endtask
  task automatic rst();
    @(negedge ref_clk_i);
    resetn_i = 0;
    repeat (3) @(negedge ref_clk_i);
    resetn_i = 1;
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial forever #50 ref_clk_i = ~ref_clk_i;
  initial
  begin
    #(100 * 2000);
    error_cnt++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(negedge ref_clk_i);
    resetn_i = 1;
    k = olk_pkg::LOCK_KEY ^ 32'h0000_001f; // 27 of 32 agree
    i_prog.lock_seq(k, ka, ca);
    chk(ka === 1'b1 && ca === 1'b1 && cells_o === k, "commit readout");
    dbg_req_i = 1;
    repeat (2) @(negedge ref_clk_i);
    chk(dbg_en_o === 1'b1, "debug open");
    rst();
    chk(locked_o === vote(k) && locked_o === 1'b0, "vote 27");
    repeat (8)
    begin
      rnd = lfsr(rnd);
      blk_sel_i = rnd[1:0];
      blk_allow_i = rnd[5:2];
      pulse(3'b001);
      chk(blk_go_o === blk_allow_i[blk_sel_i], "block permit");
    end
    prot_i = 2'h1;
    pulse(3'b100);
    chk(prot_o === 2'h1, "raise");
    prot_i = 2'h0;
    pulse(3'b100);
    chk(prot_o === 2'h1, "no lower");
    i_prog.lock_seq(olk_pkg::LOCK_KEY, ka, ca);
    chk(ka === 1'b0 && cells_o === k, "key under protection");
    pulse(3'b010);
    chk(prot_o === 2'h0, "erase");
    k = olk_pkg::LOCK_KEY ^ 32'h8100_0104 ^ {rnd[7:0], 24'h0} & 32'h0; // 28 of 32 agree
    i_prog.lock_seq(k, ka, ca);
    chk(ka === 1'b1 && ca === 1'b1 && cells_o === k, "commit 28");
    chk(locked_o === 1'b0 && dbg_en_o === 1'b1, "open until reset");
    rst();
    chk(locked_o === vote(k) && locked_o === 1'b1, "vote 28");
    repeat (2) @(negedge ref_clk_i);
    chk(dbg_en_o === 1'b0, "ports shut");
    i_prog.lock_seq(~k, ka, ca);
    chk(ka === 1'b0 && cells_o === k && locked_o === 1'b1, "latch frozen");
    prot_i = 2'h1;
    blk_allow_i = 4'hf;
    pulse(3'b101);
    chk(prot_o === 2'h0 && blk_go_o === 1'b0, "locked refuses");
    complete_run();
  end
endmodule // tb_top
